// *** hdl/adfp_defs.svh ***
`ifndef ADFP_DEFS_SVH
`define ADFP_DEFS_SVH

// Register byte addresses
`define ADFP_OFF_PLL        12'h000
`define ADFP_OFF_ATTRIBUTE_AREA_ZERO_CONFIG       12'h004
`define ADFP_OFF_ATTRIBUTE_AREA_ONE_CONFIG       12'h008
`define ADFP_OFF_BWC        12'h00C
`define ADFP_OFF_STAT       12'h010
`define ADFP_OFF_ENTRY      12'h014

// Wait-state fields of bus_wait_config
`define ADFP_BWC_A0_LSB     0
`define ADFP_BWC_A1_LSB     5

// Reset values
`define ADFP_PLL_RST        24'h000000
`define ADFP_AAR_RST        24'h000000

// Boot settings
`define ADFP_BOOT_ATTRIBUTE_AREA_ONE_CONFIG      24'hD00409
`define ADFP_BOOT_BASE      24'hD00000
`define ADFP_BOOT_WS        6'h1F
`define ADFP_ACC_SRAM       2'h1

// Flash access time against core rate gives the normal wait states
`define ADFP_FLASH_ACC_NS   200
`define ADFP_CORE_MHZ       80
`define ADFP_FLASH_WS       (`ADFP_FLASH_ACC_NS * `ADFP_CORE_MHZ / 1000)

// Round trip from output flop through pin synchroniser
`define ADFP_RD_LAT         6'h03

`endif

// *** hdl/adfp_pkg.sv ***
package adfp_pkg;

    typedef enum logic [1:0] {ADFP_SP_P, ADFP_SP_X, ADFP_SP_Y} adfp_space_t;

    typedef struct packed {
        logic [11:0] msb_match;
        logic [3:0]  ncmp;
        logic        pack_en;
        logic        swap;
        logic        en_y;
        logic        en_x;
        logic        en_p;
        logic        act_high;
        logic [1:0]  acc_type;
    } adfp_aar_t;

    typedef struct packed {
        logic [3:0]  prediv;
        logic        core_clk_dis;
        logic        pll_en;
        logic        run_in_stop;
        logic        xtal_dis;
        logic        low_xtal;
        logic [2:0]  lp_div;
        logic [11:0] mult_m1;
    } adfp_pll_t;

    typedef struct packed {
        logic        valid;
        adfp_space_t space;
        logic        wr;
        logic        dma;
        logic [23:0] addr;
        logic [23:0] wdata;
    } adfp_req_t;

    typedef struct packed {
        logic [23:0] addr;
        logic [7:0]  wdata;
        logic        cyc;
        logic        we_n;
        logic        oe_n;
    } adfp_ext_t;

endpackage

// *** hdl/adfp_top.sv ***
// Our own choices: the APB register port and the register addresses.
`include "adfp_defs.svh"
// Operation
// - Boot mode one sets attribute line one for program space $D00000-$DFFFFF.
// - Boot reads flash bytes, packs three per 24-bit word, stores to program RAM.
// - First packed boot word is the number of words to load.
// - Second packed word is load address and also the jump address.
// - Every external access during boot uses thirty-one wait states.
// - Normal flash access with 80 MHz core and 200 ns part uses sixteen waits.
// - Outside packed accesses, only the low eight bits of a word reach the flash.
// - Access type field value 1 selects asynchronous SRAM cycles.
// - Polarity bit set drives the pin high when selected, else low.
// - Bits 3, 4, 5 enable the pin for program, X and Y spaces.
// - Swap bit moves low eight address bits to top address lines.
// - Pack bit uses packing logic for DMA accesses to the area.
// - Bits 8-11 give compared bit count, bits 12-23 the match value.
// - Value 100591 in area one selects X $100000-$17FFFF, low, packed.
// - Value 140695 in area zero drives upper address high in upper half.
// - Clock register holds multiplier-1, low-power divider and predivider fields.
// - Clock register bits 15-19 are crystal, drive, stop, enable, clock-out controls.
// - Wait-state register holds area zero count bits 0-4, area one bits 5-9.
module adfp_top
    import adfp_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        boot_mode_one,
    input  wire adfp_req_t   core_req,
    output logic             core_ready,
    output logic             core_ack,
    output logic      [23:0] core_rdata,
    output adfp_ext_t        ext,
    input  wire logic [7:0]  ext_data_in,
    output logic             ext_data_oe,
    output logic             attribute_pin_zero,
    output logic             attribute_pin_one,
    output logic             pram_we,
    output logic      [23:0] pram_addr,
    output logic      [23:0] pram_data,
    output logic             boot_busy,
    output logic             boot_done,
    output logic      [23:0] boot_entry,
    output adfp_pll_t        pll_clock_cfg
);

    typedef enum {EN_IDLE, EN_ACC} adfp_en_state_t;
    typedef enum {BT_STRAP, BT_CNT, BT_DEST, BT_LOAD, BT_DONE, BT_OFF} adfp_bt_state_t;

    adfp_pll_t      pll_clock_config_r;
    adfp_aar_t      attribute_area_zero_config_r;
    adfp_aar_t      attribute_area_one_config_r;
    logic [23:0]    bus_wait_config_r;
    logic [31:0]    prdata_r;
    adfp_en_state_t en_state_r;
    adfp_req_t      cur_r;
    logic [1:0]     byte_r;
    logic [5:0]     ws_r;
    logic [23:0]    rdata_r;
    logic           ack_r;
    adfp_ext_t      ext_r;
    logic           pin0_r;
    logic           pin1_r;
    logic [7:0]     din_s1_r;
    logic [7:0]     din_s2_r;
    logic           strap_s1_r;
    logic           strap_s2_r;
    logic [1:0]     strap_cnt_r;
    adfp_bt_state_t bt_state_r;
    logic           bt_pend_r;
    logic [23:0]    bt_src_r;
    logic [23:0]    words_left_r;
    logic [23:0]    dest_r;
    logic           pram_we_r;
    logic [23:0]    pram_addr_r;
    logic [23:0]    pram_data_r;
    logic           boot_done_r;

    // Area decode shared by the engine and the pins
    function automatic logic attr_hit(input adfp_aar_t a, input adfp_space_t sp,
                                      input logic [23:0] ad);
        logic [11:0] mask;
        logic        en;
        mask = 12'h000;
        en   = 1'b0;
        for (int i = 0; i < 12; i++) begin
            mask[11 - i] = (4'(i) < a.ncmp);
        end
        unique case (sp)
            ADFP_SP_P: en = a.en_p;
            ADFP_SP_X: en = a.en_x;
            ADFP_SP_Y: en = a.en_y;
            default:   en = 1'b0;
        endcase
        return en && (a.acc_type == `ADFP_ACC_SRAM)
            && (((ad[23:12] ^ a.msb_match) & mask) == 12'h000);
    endfunction

    function automatic logic [5:0] ws_limit(input logic h0, input logic h1,
                                            input logic boot, input logic [23:0] bwc);
        logic [5:0] w;
        w = 6'h00;
        if (boot) begin
            w = `ADFP_BOOT_WS;
        end else if (h0) begin
            w = {1'b0, bwc[`ADFP_BWC_A0_LSB +: 5]};
        end else if (h1) begin
            w = {1'b0, bwc[`ADFP_BWC_A1_LSB +: 5]};
        end
        return w + `ADFP_RD_LAT;
    endfunction

    // APB decode
    logic apb_wr;
    logic mapped;
    logic cfg_lock;
    assign mapped   = paddr inside {`ADFP_OFF_PLL, `ADFP_OFF_ATTRIBUTE_AREA_ZERO_CONFIG, `ADFP_OFF_ATTRIBUTE_AREA_ONE_CONFIG,
                                    `ADFP_OFF_BWC, `ADFP_OFF_STAT, `ADFP_OFF_ENTRY};
    assign apb_wr   = psel && penable && pwrite && mapped;
    assign pready   = 1'b1;
    assign pslverr  = psel && penable && !mapped;
    assign prdata   = prdata_r;
    assign cfg_lock = boot_busy || (en_state_r == EN_ACC);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pll_clock_config_r <= `ADFP_PLL_RST;
        end else if (apb_wr && paddr == `ADFP_OFF_PLL) begin
            pll_clock_config_r <= pwdata[23:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            attribute_area_zero_config_r <= `ADFP_AAR_RST;
        end else if (apb_wr && paddr == `ADFP_OFF_ATTRIBUTE_AREA_ZERO_CONFIG && !cfg_lock) begin
            attribute_area_zero_config_r <= pwdata[23:0];
        end
    end

    // Boot start overrides software for area one
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            attribute_area_one_config_r <= `ADFP_AAR_RST;
        end else if (bt_state_r == BT_STRAP && strap_cnt_r == 2'h3 && strap_s2_r) begin
            attribute_area_one_config_r <= `ADFP_BOOT_ATTRIBUTE_AREA_ONE_CONFIG;
        end else if (apb_wr && paddr == `ADFP_OFF_ATTRIBUTE_AREA_ONE_CONFIG && !cfg_lock) begin
            attribute_area_one_config_r <= pwdata[23:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bus_wait_config_r <= 24'((`ADFP_FLASH_WS << `ADFP_BWC_A1_LSB)
                                     | (`ADFP_FLASH_WS << `ADFP_BWC_A0_LSB));
        end else if (apb_wr && paddr == `ADFP_OFF_BWC && !cfg_lock) begin
            bus_wait_config_r <= {14'h0000, pwdata[9:0]};
        end
    end

    // Read data is latched in the setup phase so it stands during access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r <= 32'h00000000;
        end else if (psel && !penable) begin
            unique case (paddr)
                `ADFP_OFF_PLL:   prdata_r <= {8'h00, pll_clock_config_r};
                `ADFP_OFF_ATTRIBUTE_AREA_ZERO_CONFIG:  prdata_r <= {8'h00, attribute_area_zero_config_r};
                `ADFP_OFF_ATTRIBUTE_AREA_ONE_CONFIG:  prdata_r <= {8'h00, attribute_area_one_config_r};
                `ADFP_OFF_BWC:   prdata_r <= {8'h00, bus_wait_config_r};
                `ADFP_OFF_STAT:  prdata_r <= {29'h00000000, en_state_r == EN_ACC,
                                              boot_busy, boot_done_r};
                `ADFP_OFF_ENTRY: prdata_r <= {8'h00, dest_r};
                default:         prdata_r <= 32'h00000000;
            endcase
        end
    end

    assign pll_clock_cfg = pll_clock_config_r;

    // Pin synchronisers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            din_s1_r   <= 8'h00;
            din_s2_r   <= 8'h00;
            strap_s1_r <= 1'b0;
            strap_s2_r <= 1'b0;
        end else begin
            din_s1_r   <= ext_data_in;
            din_s2_r   <= din_s1_r;
            strap_s1_r <= boot_mode_one;
            strap_s2_r <= strap_s1_r;
        end
    end

    // Access engine
    adfp_req_t  boot_req;
    adfp_req_t  grant;
    logic       start;
    logic       g_hit0;
    logic       g_hit1;
    logic       hit0;
    logic       hit1;
    logic       pack_c;
    logic [1:0] last_byte;
    logic       byte_end;

    assign boot_busy  = bt_state_r inside {BT_CNT, BT_DEST, BT_LOAD};
    assign grant      = boot_busy ? boot_req : core_req;
    assign start      = (en_state_r == EN_IDLE) && grant.valid;
    assign core_ready = (en_state_r == EN_IDLE) && !boot_busy;
    assign g_hit0     = attr_hit(attribute_area_zero_config_r, grant.space, grant.addr);
    assign g_hit1     = attr_hit(attribute_area_one_config_r, grant.space, grant.addr);
    assign hit0       = attr_hit(attribute_area_zero_config_r, cur_r.space, cur_r.addr);
    assign hit1       = attr_hit(attribute_area_one_config_r, cur_r.space, cur_r.addr);
    assign pack_c     = cur_r.dma && (boot_busy || (hit0 && attribute_area_zero_config_r.pack_en)
                                      || (hit1 && attribute_area_one_config_r.pack_en));
    assign last_byte  = pack_c ? 2'h2 : 2'h0;
    assign byte_end   = (en_state_r == EN_ACC) && (ws_r == 6'h00);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_state_r <= EN_IDLE;
            cur_r      <= '0;
            byte_r     <= 2'h0;
            ws_r       <= 6'h00;
        end else begin
            unique case (en_state_r)
                EN_IDLE: if (start) begin
                    en_state_r <= EN_ACC;
                    cur_r      <= grant;
                    byte_r     <= 2'h0;
                    ws_r       <= ws_limit(g_hit0, g_hit1, boot_busy,
                                           bus_wait_config_r);
                end
                EN_ACC: if (ws_r != 6'h00) begin
                    ws_r <= ws_r - 6'h01;
                end else if (byte_r == last_byte) begin
                    en_state_r <= EN_IDLE;
                end else begin
                    byte_r <= byte_r + 2'h1;
                    ws_r   <= ws_limit(hit0, hit1, boot_busy, bus_wait_config_r);
                end
            endcase
        end
    end

    // Read bytes assemble low byte first
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_r <= 24'h000000;
            ack_r   <= 1'b0;
        end else begin
            ack_r <= byte_end && (byte_r == last_byte);
            if (byte_end && !cur_r.wr) begin
                if (pack_c) begin
                    rdata_r[8 * byte_r +: 8] <= din_s2_r;
                end else begin
                    rdata_r <= {16'h0000, din_s2_r};
                end
            end
        end
    end

    assign core_ack   = ack_r && !boot_busy;
    assign core_rdata = rdata_r;

    // External pins, strobes drop on the last count for a gap between bytes
    logic [23:0] baddr;
    logic        swap_c;
    logic        strobe;
    assign baddr  = cur_r.addr + {22'h000000, byte_r};
    assign swap_c = (hit0 && attribute_area_zero_config_r.swap) || (hit1 && attribute_area_one_config_r.swap);
    assign strobe = (en_state_r == EN_ACC) && (ws_r != 6'h00);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_r  <= '{addr: 24'h000000, wdata: 8'h00, cyc: 1'b0, we_n: 1'b1, oe_n: 1'b1};
            pin0_r <= 1'b1;
            pin1_r <= 1'b1;
        end else begin
            ext_r.addr  <= swap_c ? {baddr[7:0], baddr[23:8]} : baddr;
            ext_r.wdata <= pack_c ? cur_r.wdata[8 * byte_r +: 8] : cur_r.wdata[7:0];
            ext_r.cyc   <= en_state_r == EN_ACC;
            ext_r.we_n  <= !(strobe && cur_r.wr);
            ext_r.oe_n  <= !(strobe && !cur_r.wr);
            pin0_r <= (en_state_r == EN_ACC && hit0) ? attribute_area_zero_config_r.act_high
                                                     : !attribute_area_zero_config_r.act_high;
            pin1_r <= (en_state_r == EN_ACC && hit1) ? attribute_area_one_config_r.act_high
                                                     : !attribute_area_one_config_r.act_high;
        end
    end

    assign ext                = ext_r;
    assign ext_data_oe        = ext_r.cyc && !ext_r.we_n;
    assign attribute_pin_zero = pin0_r;
    assign attribute_pin_one  = pin1_r;

    // Boot loader
    assign boot_req = '{valid: !bt_pend_r, space: ADFP_SP_P, wr: 1'b0, dma: 1'b1,
                        addr: bt_src_r, wdata: 24'h000000};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bt_state_r   <= BT_STRAP;
            strap_cnt_r  <= 2'h0;
            bt_pend_r    <= 1'b0;
            bt_src_r     <= `ADFP_BOOT_BASE;
            words_left_r <= 24'h000000;
            dest_r       <= 24'h000000;
        end else begin
            if (boot_busy && start) begin
                bt_pend_r <= 1'b1;
                bt_src_r  <= bt_src_r + 24'h000003;
            end else if (ack_r) begin
                bt_pend_r <= 1'b0;
            end
            unique case (bt_state_r)
                BT_STRAP: begin
                    strap_cnt_r <= strap_cnt_r + 2'h1;
                    if (strap_cnt_r == 2'h3) begin
                        bt_state_r <= strap_s2_r ? BT_CNT : BT_OFF;
                    end
                end
                BT_CNT: if (ack_r) begin
                    words_left_r <= rdata_r;
                    bt_state_r   <= BT_DEST;
                end
                BT_DEST: if (ack_r) begin
                    dest_r     <= rdata_r;
                    bt_state_r <= (words_left_r == 24'h000000) ? BT_DONE : BT_LOAD;
                end
                BT_LOAD: if (ack_r) begin
                    words_left_r <= words_left_r - 24'h000001;
                    if (words_left_r == 24'h000001) begin
                        bt_state_r <= BT_DONE;
                    end
                end
                BT_DONE: bt_state_r <= BT_DONE;
                BT_OFF:  bt_state_r <= BT_OFF;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pram_we_r   <= 1'b0;
            pram_addr_r <= 24'h000000;
            pram_data_r <= 24'h000000;
            boot_done_r <= 1'b0;
        end else begin
            pram_we_r   <= ack_r && bt_state_r == BT_LOAD;
            boot_done_r <= bt_state_r == BT_DONE;
            if (ack_r && bt_state_r == BT_DEST) begin
                pram_addr_r <= rdata_r;
            end else if (pram_we_r) begin
                pram_addr_r <= pram_addr_r + 24'h000001;
            end
            if (ack_r && bt_state_r == BT_LOAD) begin
                pram_data_r <= rdata_r;
            end
        end
    end

    assign pram_we    = pram_we_r;
    assign pram_addr  = pram_addr_r;
    assign pram_data  = pram_data_r;
    assign boot_done  = boot_done_r;
    assign boot_entry = dest_r;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    property p_boot_attribute_area_one_config;
        boot_busy |-> attribute_area_one_config_r == `ADFP_BOOT_ATTRIBUTE_AREA_ONE_CONFIG;
    endproperty
    a_boot_attribute_area_one_config: assert property (p_boot_attribute_area_one_config) else $error("boot area one wrong");

    property p_boot_ws;
        start && boot_busy |=> ws_r == 6'(`ADFP_BOOT_WS + `ADFP_RD_LAT);
    endproperty
    a_boot_ws: assert property (p_boot_ws) else $error("boot wait count wrong");

    property p_area0_ws;
        start && !boot_busy && g_hit0
            |=> ws_r == {1'b0, $past(bus_wait_config_r[4:0])} + `ADFP_RD_LAT;
    endproperty
    a_area0_ws: assert property (p_area0_ws) else $error("area zero waits wrong");

    property p_pin_idle;
        !ext_r.cyc |-> attribute_pin_zero == !$past(attribute_area_zero_config_r.act_high);
    endproperty
    a_pin_idle: assert property (p_pin_idle) else $error("pin active while idle");

    property p_pin_sel;
        ext_r.cyc && attribute_pin_one == $past(attribute_area_one_config_r.act_high) |-> $past(hit1);
    endproperty
    a_pin_sel: assert property (p_pin_sel) else $error("pin asserted without hit");

    property p_low_byte;
        ext_data_oe && !$past(pack_c) |-> ext_r.wdata == $past(cur_r.wdata[7:0]);
    endproperty
    a_low_byte: assert property (p_low_byte) else $error("upper data bits leaked");

    property p_pack;
        ack_r && $past(pack_c) |-> $past(byte_r) == 2'h2 ##1 en_state_r == EN_IDLE;
    endproperty
    a_pack: assert property (p_pack) else $error("packed access not three bytes");

    property p_count;
        ack_r && bt_state_r == BT_CNT |=> words_left_r == $past(rdata_r);
    endproperty
    a_count: assert property (p_count) else $error("word count not taken");

    property p_jump;
        $rose(boot_done) |-> boot_entry == dest_r && !boot_busy;
    endproperty
    a_jump: assert property (p_jump) else $error("entry address wrong");

    property p_pram;
        pram_we |-> $past(ack_r) && pram_data == $past(rdata_r);
    endproperty
    a_pram: assert property (p_pram) else $error("program word not stored");

    c_boot_done: cover property ($rose(boot_done));
    c_pack_acc:  cover property (ack_r && $past(pack_c) && !boot_busy);
    c_pin_sel:   cover property (ext_r.cyc && attribute_pin_one == attribute_area_one_config_r.act_high);
    c_apb_err:   cover property (pslverr);

endmodule

// *** testbench/adfp_flash_model.sv ***
module adfp_flash_model
    import adfp_pkg::*;
#(
    parameter int PROG_CYC = 300
)
(
    input  wire logic       pclk,
    input  wire adfp_ext_t  ext,
    output logic      [7:0] data_out
);
    logic [7:0]  mem [int];
    logic [1:0]  unl_r = '0;
    logic        pend_r = 1'b0;
    logic [18:0] wa_r;
    logic [7:0]  wd_r;
    logic [7:0]  last_r = '0;
    logic [7:0]  drive_r = '0;
    int          left_r = 0;
    int          busy_r = 0;
    // Poll sees inverted data while programming; released bus toggles
    always @* begin
        if (ext.cyc && !ext.oe_n)
            data_out = busy_r > 0 ? ~last_r :
                (mem.exists(ext.addr[18:0]) ? mem[ext.addr[18:0]] : 8'hFF);
        else
            data_out = ~drive_r;
    end
    always @(posedge pclk) begin
        drive_r <= data_out;
        if (busy_r > 0)
            busy_r <= busy_r - 1;
        if (ext.cyc && !ext.we_n) begin
            pend_r <= 1'b1;
            wa_r <= ext.addr[18:0];
            wd_r <= ext.wdata;
        end else if (pend_r) begin
            pend_r <= 1'b0;
            if (busy_r > 0) begin
            end else if (left_r > 0) begin
                // Whole sector is erased before the first byte lands
                if (left_r == 256)
                    for (int k = 0; k < 256; k++) mem[{wa_r[18:8], k[7:0]}] = 8'hFF;
                mem[wa_r] = wd_r;
                left_r <= left_r - 1;
                last_r <= wd_r;
                if (left_r == 1)
                    busy_r <= PROG_CYC;
            end else begin
                case (unl_r)
                    2'd0: unl_r <= (wa_r == 19'h05555 && wd_r == 8'hAA) ? 2'd1 : 2'd0;
                    2'd1: unl_r <= (wa_r == 19'h02AAA && wd_r == 8'h55) ? 2'd2 : 2'd0;
                    default: begin
                        unl_r <= 2'd0;
                        if (wa_r == 19'h05555 && wd_r == 8'hA0)
                            left_r <= 256;
                    end
                endcase
            end
        end
    end
endmodule

// *** testbench/tb_attribute_decode_flash_program.sv ***
module tb_attribute_decode_flash_program
    import adfp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, boot_mode_one = 1;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic        pready, pslverr, se, core_ready, core_ack, ext_data_oe, pram_we;
    logic        boot_busy, boot_done, attribute_pin_zero, attribute_pin_one, pz, po;
    adfp_req_t   core_req = '0;
    logic [23:0] core_rdata, pram_addr, pram_data, boot_entry, cr;
    adfp_ext_t   ext;
    adfp_pll_t   pll_clock_cfg;
    logic [7:0]  ext_data_in;
    logic [47:0] pr [4];
    logic [95:0] img = 96'hABCDEF_123456_000100_000002;
    int          errors = 0, cmp_count = 0, cyc = 0, run = 0, blen = 0, llen = 0, np = 0;
    int          i, l0;
    adfp_top u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .boot_mode_one, .core_req, .core_ready, .core_ack, .core_rdata,
        .ext, .ext_data_in, .ext_data_oe, .attribute_pin_zero, .attribute_pin_one, .pram_we,
        .pram_addr, .pram_data, .boot_busy, .boot_done, .boot_entry, .pll_clock_cfg);
    adfp_flash_model u_flash (.pclk, .ext, .data_out(ext_data_in));
    always #5 pclk = ~pclk;
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            errors++;
            give_verdict;
        end
    end
    // Strobe lengths, pin levels during cycles, program RAM stores
    always @(negedge pclk) begin
        if (ext.oe_n === 1'b0)
            run++;
        else if (run != 0) begin
            if (boot_busy === 1'b1 && blen == 0)
                blen = run;
            llen = run;
            run = 0;
        end
        if (ext.cyc === 1'b1) begin
            pz = attribute_pin_zero;
            po = attribute_pin_one;
        end
        if (pram_we === 1'b1) begin
            pr[np] = {pram_addr, pram_data};
            np++;
        end
    end
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        cmp_count++;
        if (s !== e) begin
            errors++;
            $display("BAD %s exp %h seen %h", n, e, s);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        se = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic creq(input adfp_space_t s, input logic w, input logic dm,
                        input logic [23:0] a, input logic [23:0] d);
        core_req <= '{1'b1, s, w, dm, a, d};
        do @(posedge pclk); while (core_ready !== 1'b1);
        core_req.valid <= 1'b0;
        do @(posedge pclk); while (core_ack !== 1'b1);
        cr = core_rdata;
    endtask
    task automatic give_verdict;
        if (errors == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial begin
        for (i = 0; i < 12; i++) u_flash.mem[i] = img[8*i+:8];
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(0, 12'h000, 0);
        chk("pll", rd, 32'h0);
        apb(0, 12'h00C, 0);
        chk("bwc", rd, 32'h210);
        apb(0, 12'h020, 0);
        chk("slverr", se, 1);
        do @(negedge pclk); while (boot_done !== 1'b1);
        chk("entry", boot_entry, 24'h100);
        chk("nstore", np, 2);
        chk("store0", pr[0], 48'h000100_123456);
        chk("store1", pr[1], 48'h000101_ABCDEF);
        chk("bootpin", {pz, po}, 2'b10);
        @(posedge pclk);
        apb(1, 12'h000, 32'h0E0013);
        chk("pllf", pll_clock_cfg, 24'h0E0013);
        apb(1, 12'h004, 32'h140695);
        apb(1, 12'h008, 32'h100591);
        apb(0, 12'h008, 0);
        chk("attribute_area_one_config", rd, 32'h100591);
        apb(1, 12'h00C, 0);
        creq(ADFP_SP_X, 0, 0, 24'h100000, 0);
        l0 = llen;
        chk("lowx", {pz, po}, 2'b00);
        chk("bootws", blen - l0, 31);
        creq(ADFP_SP_X, 0, 0, 24'h150000, 0);
        chk("upx", {pz, po}, 2'b10);
        creq(ADFP_SP_Y, 0, 0, 24'h100000, 0);
        chk("ysp", po, 1);
        creq(ADFP_SP_X, 0, 0, 24'h180000, 0);
        chk("nomatch", po, 1);
        creq(ADFP_SP_X, 0, 1, 24'h100000, 0);
        chk("pack", cr, 24'h000002);
        apb(1, 12'h00C, 32'h010);
        creq(ADFP_SP_X, 0, 0, 24'h100000, 0);
        chk("ws1a", llen - l0, 0);
        creq(ADFP_SP_X, 0, 0, 24'h150000, 0);
        chk("ws0", llen - l0, 16);
        apb(1, 12'h00C, 32'h200);
        creq(ADFP_SP_X, 0, 0, 24'h100000, 0);
        chk("ws1b", llen - l0, 16);
        apb(1, 12'h008, 32'h100590);
        creq(ADFP_SP_X, 0, 0, 24'h100000, 0);
        chk("acctype", po, 1);
        apb(1, 12'h008, 32'h100591);
        apb(1, 12'h00C, 0);
        creq(ADFP_SP_X, 1, 0, 24'h105555, 24'hFFFFAA);
        creq(ADFP_SP_X, 1, 0, 24'h102AAA, 24'hFFFF55);
        creq(ADFP_SP_X, 1, 0, 24'h105555, 24'hFFFFA0);
        for (i = 0; i < 256; i++) creq(ADFP_SP_X, 1, 0, 24'h17FF00 + i, {16'hABCD, i[7:0] ^ 8'h5A});
        i = 0;
        do begin
            creq(ADFP_SP_X, 0, 0, 24'h17FFFF, 0);
            i++;
        end while (cr[7:0] !== 8'hA5 && i < 200);
        chk("poll", cr[7:0], 8'hA5);
        creq(ADFP_SP_X, 0, 0, 24'h17FF10, 0);
        chk("byte", cr[7:0], 8'h4A);
        give_verdict;
    end
endmodule
